//--- src/cmso_pkg.sv
// Constants, types and encodings shared by the multiply/OR/stack execution slice
// Contract
// - Multiply even register of destination pair by 8-bit source; opcodes 84, 85, 86.
// - Multiply sets carry above 255, zero, sign from product top; clears overflow.
// - Threaded-next loads PC from word at instruction pointer, then adds two; 10 cycles.
// - No-operation FF is one byte, 4 cycles, and changes nothing.
// - OR stores source OR destination into destination; opcodes 42 through 46.
// - OR sets zero and sign from result, clears overflow, keeps other flags.
// - System pop copies byte at stack pointer to destination, then increments; 8 cycles.
// - Opcode 92 pops via user pointer register, then decrements that pointer.
// - Opcode 93 pops via user pointer register, then increments that pointer; 8 cycles.
// - System push decrements stack pointer first, then stores source there; 8 cycles.
// - Next, no-operation, pops and pushes leave every status flag unchanged.
// - Stack pointer is high byte at D8h and low byte at D9h, used together.
package cmso_pkg;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_OR_RR = 8'h42;
    localparam logic [7:0] OP_OR_RI = 8'h43;
    localparam logic [7:0] OP_OR_R = 8'h44;
    localparam logic [7:0] OP_OR_IR = 8'h45;
    localparam logic [7:0] OP_OR_IM = 8'h46;
    localparam logic [7:0] OP_MUL_R = 8'h84;
    localparam logic [7:0] OP_MUL_IR = 8'h85;
    localparam logic [7:0] OP_MUL_IM = 8'h86;
    localparam logic [7:0] OP_NEXT = 8'h0f;
    localparam logic [7:0] OP_NOP = 8'hff;
    localparam logic [7:0] OP_POP_R = 8'h50;
    localparam logic [7:0] OP_POP_IR = 8'h51;
    localparam logic [7:0] OP_PUSH_R = 8'h70;
    localparam logic [7:0] OP_PUSH_IR = 8'h71;
    localparam logic [7:0] OP_UPOP_DN = 8'h92;
    localparam logic [7:0] OP_UPOP_UP = 8'h93;

    // ************************************************************
    // Cycle counts per instruction
    // ************************************************************
    localparam logic [4:0] CYC_MUL = 5'h16;
    localparam logic [4:0] CYC_NEXT = 5'h0a;
    localparam logic [4:0] CYC_NOP = 5'h04;
    localparam logic [4:0] CYC_OR_SHORT = 5'h04;
    localparam logic [4:0] CYC_OR_LONG = 5'h06;
    localparam logic [4:0] CYC_STACK = 5'h08;
    localparam logic [4:0] CYC_BAD = 5'h01;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] RF_SPH = 8'hd8;
    localparam logic [7:0] RF_SPL = 8'hd9;
    localparam logic [7:0] RF_WORK_BASE = 8'hc0;
    localparam logic [9:0] IDX_RF_TOP = 10'h0ff;
    localparam logic [9:0] IDX_CMD = 10'h100;
    localparam logic [9:0] IDX_STAT = 10'h101;
    localparam logic [9:0] IDX_FLAGS = 10'h102;
    localparam logic [9:0] IDX_PC = 10'h103;
    localparam logic [9:0] IDX_IP = 10'h104;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned FL_C = 7;
    localparam int unsigned FL_Z = 6;
    localparam int unsigned FL_S = 5;
    localparam int unsigned FL_V = 4;
    localparam int unsigned FL_D = 3;
    localparam int unsigned FL_H = 2;
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_ERR = 1;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] IP_RST = 16'h0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] op;
    } cmso_cmd_t;

    typedef enum logic [2:0] {
        CMSO_IDLE,
        CMSO_EXEC,
        CMSO_FHI,
        CMSO_FLO,
        CMSO_RUN
    } cmso_state_t;

endpackage

//--- src/cmso_exec.sv
// Execution slice for multiply, OR, next, no-operation and stack instructions
`timescale 1ns/100ps
`default_nettype none
module cmso_exec #(
    parameter int unsigned RF_DEPTH = 256
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [15:0] o_pmem_addr,
    output logic o_pmem_rd,
    input wire logic [7:0] i_pmem_data,
    input wire logic i_pmem_valid
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    generate
        if (RF_DEPTH != 256) begin : g_bad_depth
            $error("cmso_exec needs a 256-byte register file");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [RF_DEPTH-1:0][7:0] rf;
        cmso_pkg::cmso_state_t st;
        cmso_pkg::cmso_cmd_t cmd;
        logic [4:0] cnt;
        logic [7:0] flags;
        logic [15:0] pc;
        logic [15:0] ip;
        logic [7:0] fhi;
        logic err;
        logic wreq;
        logic [31:0] rdata;
        logic [15:0] pa;
        logic prd;
    } cmso_state_reg_t;

    cmso_state_reg_t q_ff;
    cmso_state_reg_t nxt_q;

    logic [9:0] idx;
    logic req;
    logic allowed;
    logic take;
    logic [7:0] dst;
    logic [7:0] srcv;
    logic [7:0] uptr_a;
    logic [7:0] or_res;
    logic [15:0] prod;
    logic [15:0] sp;
    logic [4:0] cyc;
    logic known;
    logic [31:0] rd_mux;

    // Bus decode
    assign idx = i_avs_address[11:2];
    assign req = i_avs_read | i_avs_write;
    assign allowed = (q_ff.st == cmso_pkg::CMSO_IDLE) || (idx == cmso_pkg::IDX_STAT) || i_avs_read;
    assign take = req && !q_ff.wreq;
    assign sp = {q_ff.rf[cmso_pkg::RF_SPH], q_ff.rf[cmso_pkg::RF_SPL]};

    // ************************************************************
    // Operand decode
    // ************************************************************
    always_comb begin
        dst = 8'h00;
        srcv = 8'h00;
        uptr_a = q_ff.cmd.b1;
        cyc = cmso_pkg::CYC_BAD;
        known = 1'b1;
        unique case (q_ff.cmd.op)
            cmso_pkg::OP_OR_RR: begin
                dst = cmso_pkg::RF_WORK_BASE + {4'h0, q_ff.cmd.b1[7:4]};
                srcv = q_ff.rf[cmso_pkg::RF_WORK_BASE + {4'h0, q_ff.cmd.b1[3:0]}];
                cyc = cmso_pkg::CYC_OR_SHORT;
            end
            cmso_pkg::OP_OR_RI: begin
                dst = cmso_pkg::RF_WORK_BASE + {4'h0, q_ff.cmd.b1[7:4]};
                srcv = q_ff.rf[q_ff.rf[cmso_pkg::RF_WORK_BASE + {4'h0, q_ff.cmd.b1[3:0]}]];
                cyc = cmso_pkg::CYC_OR_LONG;
            end
            cmso_pkg::OP_OR_R: begin
                dst = q_ff.cmd.b2;
                srcv = q_ff.rf[q_ff.cmd.b1];
                cyc = cmso_pkg::CYC_OR_LONG;
            end
            cmso_pkg::OP_OR_IR: begin
                dst = q_ff.cmd.b2;
                srcv = q_ff.rf[q_ff.rf[q_ff.cmd.b1]];
                cyc = cmso_pkg::CYC_OR_LONG;
            end
            cmso_pkg::OP_OR_IM: begin
                dst = q_ff.cmd.b1;
                srcv = q_ff.cmd.b2;
                cyc = cmso_pkg::CYC_OR_LONG;
            end
            cmso_pkg::OP_MUL_R: begin
                dst = q_ff.cmd.b2 & 8'hfe;
                srcv = q_ff.rf[q_ff.cmd.b1];
                cyc = cmso_pkg::CYC_MUL;
            end
            cmso_pkg::OP_MUL_IR: begin
                dst = q_ff.cmd.b2 & 8'hfe;
                srcv = q_ff.rf[q_ff.rf[q_ff.cmd.b1]];
                cyc = cmso_pkg::CYC_MUL;
            end
            cmso_pkg::OP_MUL_IM: begin
                dst = q_ff.cmd.b2 & 8'hfe;
                srcv = q_ff.cmd.b1;
                cyc = cmso_pkg::CYC_MUL;
            end
            cmso_pkg::OP_POP_R: begin
                dst = q_ff.cmd.b1;
                cyc = cmso_pkg::CYC_STACK;
            end
            cmso_pkg::OP_POP_IR: begin
                dst = q_ff.rf[q_ff.cmd.b1];
                cyc = cmso_pkg::CYC_STACK;
            end
            cmso_pkg::OP_PUSH_R: begin
                srcv = q_ff.rf[q_ff.cmd.b1];
                cyc = cmso_pkg::CYC_STACK;
            end
            cmso_pkg::OP_PUSH_IR: begin
                srcv = q_ff.rf[q_ff.rf[q_ff.cmd.b1]];
                cyc = cmso_pkg::CYC_STACK;
            end
            cmso_pkg::OP_UPOP_DN, cmso_pkg::OP_UPOP_UP: begin
                dst = q_ff.cmd.b2;
                srcv = q_ff.rf[q_ff.rf[q_ff.cmd.b1]];
                cyc = cmso_pkg::CYC_STACK;
            end
            cmso_pkg::OP_NEXT: begin
                cyc = cmso_pkg::CYC_NEXT;
            end
            cmso_pkg::OP_NOP: begin
                cyc = cmso_pkg::CYC_NOP;
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

    // Arithmetic results
    assign or_res = q_ff.rf[dst] | srcv;
    assign prod = {8'h00, q_ff.rf[dst]} * {8'h00, srcv};

    // Read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (idx <= cmso_pkg::IDX_RF_TOP) begin
            rd_mux = {24'h00_0000, q_ff.rf[idx[7:0]]};
        end else if (idx == cmso_pkg::IDX_CMD) begin
            rd_mux = {8'h00, q_ff.cmd};
        end else if (idx == cmso_pkg::IDX_STAT) begin
            rd_mux[cmso_pkg::ST_BUSY] = q_ff.st != cmso_pkg::CMSO_IDLE;
            rd_mux[cmso_pkg::ST_ERR] = q_ff.err;
        end else if (idx == cmso_pkg::IDX_FLAGS) begin
            rd_mux = {24'h00_0000, q_ff.flags};
        end else if (idx == cmso_pkg::IDX_PC) begin
            rd_mux = {16'h0000, q_ff.pc};
        end else if (idx == cmso_pkg::IDX_IP) begin
            rd_mux = {16'h0000, q_ff.ip};
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_q = q_ff;
        // Bus handshake: one wait cycle, then accept; non-status writes are held off until idle
        nxt_q.wreq = !(req && allowed && q_ff.wreq);
        if (req && allowed && q_ff.wreq) begin
            nxt_q.rdata = rd_mux;
        end
        if (take && i_avs_write) begin
            if (idx <= cmso_pkg::IDX_RF_TOP && i_avs_byteenable[0]) begin
                nxt_q.rf[idx[7:0]] = i_avs_writedata[7:0];
            end else if (idx == cmso_pkg::IDX_CMD && i_avs_byteenable[0]) begin
                nxt_q.cmd = i_avs_writedata[23:0];
                nxt_q.st = cmso_pkg::CMSO_EXEC;
            end else if (idx == cmso_pkg::IDX_STAT && i_avs_byteenable[0]) begin
                nxt_q.err = q_ff.err & ~i_avs_writedata[cmso_pkg::ST_ERR];
            end else if (idx == cmso_pkg::IDX_FLAGS && i_avs_byteenable[0]) begin
                nxt_q.flags = i_avs_writedata[7:0];
            end else if (idx == cmso_pkg::IDX_PC) begin
                if (i_avs_byteenable[0]) nxt_q.pc[7:0] = i_avs_writedata[7:0];
                if (i_avs_byteenable[1]) nxt_q.pc[15:8] = i_avs_writedata[15:8];
            end else if (idx == cmso_pkg::IDX_IP) begin
                if (i_avs_byteenable[0]) nxt_q.ip[7:0] = i_avs_writedata[7:0];
                if (i_avs_byteenable[1]) nxt_q.ip[15:8] = i_avs_writedata[15:8];
            end
        end
        // Cycle counter runs in every busy state
        if (q_ff.cnt != 5'h00) begin
            nxt_q.cnt = q_ff.cnt - 5'h01;
        end
        unique case (q_ff.st)
            cmso_pkg::CMSO_IDLE: begin
            end
            cmso_pkg::CMSO_EXEC: begin
                nxt_q.cnt = cyc - 5'h01;
                nxt_q.st = cmso_pkg::CMSO_RUN;
                unique case (q_ff.cmd.op)
                    cmso_pkg::OP_OR_RR, cmso_pkg::OP_OR_RI, cmso_pkg::OP_OR_R,
                    cmso_pkg::OP_OR_IR, cmso_pkg::OP_OR_IM: begin
                        nxt_q.rf[dst] = or_res;
                        nxt_q.flags[cmso_pkg::FL_Z] = or_res == 8'h00;
                        nxt_q.flags[cmso_pkg::FL_S] = or_res[7];
                        nxt_q.flags[cmso_pkg::FL_V] = 1'b0;
                    end
                    cmso_pkg::OP_MUL_R, cmso_pkg::OP_MUL_IR, cmso_pkg::OP_MUL_IM: begin
                        nxt_q.rf[dst] = prod[15:8];
                        nxt_q.rf[dst | 8'h01] = prod[7:0];
                        nxt_q.flags[cmso_pkg::FL_C] = prod > 16'h00ff;
                        nxt_q.flags[cmso_pkg::FL_Z] = prod == 16'h0000;
                        nxt_q.flags[cmso_pkg::FL_S] = prod[15];
                        nxt_q.flags[cmso_pkg::FL_V] = 1'b0;
                    end
                    cmso_pkg::OP_POP_R, cmso_pkg::OP_POP_IR: begin
                        nxt_q.rf[dst] = q_ff.rf[sp[7:0]];
                        {nxt_q.rf[cmso_pkg::RF_SPH], nxt_q.rf[cmso_pkg::RF_SPL]} = sp + 16'h0001;
                    end
                    cmso_pkg::OP_PUSH_R, cmso_pkg::OP_PUSH_IR: begin
                        {nxt_q.rf[cmso_pkg::RF_SPH], nxt_q.rf[cmso_pkg::RF_SPL]} = sp - 16'h0001;
                        nxt_q.rf[sp[7:0] - 8'h01] = srcv;
                    end
                    cmso_pkg::OP_UPOP_DN: begin
                        nxt_q.rf[dst] = srcv;
                        nxt_q.rf[uptr_a] = q_ff.rf[uptr_a] - 8'h01;
                    end
                    cmso_pkg::OP_UPOP_UP: begin
                        nxt_q.rf[dst] = srcv;
                        nxt_q.rf[uptr_a] = q_ff.rf[uptr_a] + 8'h01;
                    end
                    cmso_pkg::OP_NEXT: begin
                        nxt_q.st = cmso_pkg::CMSO_FHI;
                        nxt_q.pa = q_ff.ip;
                        nxt_q.prd = 1'b1;
                    end
                    cmso_pkg::OP_NOP: begin // Nothing written, flags kept
                    end
                    default: begin
                        nxt_q.err = 1'b1;
                    end
                endcase
            end
            cmso_pkg::CMSO_FHI: begin
                if (i_pmem_valid) begin
                    nxt_q.fhi = i_pmem_data;
                    nxt_q.pa = q_ff.ip + 16'h0001;
                    nxt_q.st = cmso_pkg::CMSO_FLO;
                end
            end
            cmso_pkg::CMSO_FLO: begin
                if (i_pmem_valid) begin
                    nxt_q.pc = {q_ff.fhi, i_pmem_data};
                    nxt_q.ip = q_ff.ip + 16'h0002;
                    nxt_q.prd = 1'b0;
                    nxt_q.st = cmso_pkg::CMSO_RUN;
                end
            end
            cmso_pkg::CMSO_RUN: begin
                if (q_ff.cnt == 5'h00) begin
                    nxt_q.st = cmso_pkg::CMSO_IDLE;
                end
            end
        endcase
    end

    // State register with clock enable
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            q_ff <= '0;
            q_ff.wreq <= 1'b1;
            q_ff.st <= cmso_pkg::CMSO_IDLE;
            q_ff.flags <= cmso_pkg::FLAGS_RST;
            q_ff.pc <= cmso_pkg::PC_RST;
            q_ff.ip <= cmso_pkg::IP_RST;
        end else if (i_ce) begin
            q_ff <= nxt_q;
        end
    end

    // Outputs
    assign o_avs_readdata = q_ff.rdata;
    assign o_avs_waitrequest = q_ff.wreq;
    assign o_pmem_addr = q_ff.pa;
    assign o_pmem_rd = q_ff.prd;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk iff i_ce); endclocking
    default disable iff (i_reset);

    logic ex;
    assign ex = q_ff.st == cmso_pkg::CMSO_EXEC;

    sequence s_nop_start;
        ex && q_ff.cmd.op == cmso_pkg::OP_NOP;
    endsequence

    sequence s_mul_start;
        ex && (q_ff.cmd.op == cmso_pkg::OP_MUL_R || q_ff.cmd.op == cmso_pkg::OP_MUL_IR
               || q_ff.cmd.op == cmso_pkg::OP_MUL_IM);
    endsequence

    sequence s_or_start;
        ex && q_ff.cmd.op >= cmso_pkg::OP_OR_RR && q_ff.cmd.op <= cmso_pkg::OP_OR_IM;
    endsequence

    sequence s_run_out(int n);
        (q_ff.st == cmso_pkg::CMSO_RUN) [*1] ##0 (q_ff.cnt == n[4:0]);
    endsequence

    a_unsigned_multiply_product: assert property (s_mul_start |=>
        {q_ff.rf[$past(dst)], q_ff.rf[$past(dst) | 8'h01]} == $past(prod))
        else $error("multiply product misplaced");
    a_unsigned_multiply_flags: assert property (s_mul_start |=>
        q_ff.flags[cmso_pkg::FL_C] == ($past(prod) > 16'h00ff) && !q_ff.flags[cmso_pkg::FL_V]
        && q_ff.flags[cmso_pkg::FL_D] == $past(q_ff.flags[cmso_pkg::FL_D])
        && q_ff.flags[cmso_pkg::FL_H] == $past(q_ff.flags[cmso_pkg::FL_H]))
        else $error("multiply flags wrong");
    a_unsigned_multiply_length: assert property (s_mul_start |=> s_run_out(21) ##21 q_ff.st == cmso_pkg::CMSO_RUN
        ##1 q_ff.st == cmso_pkg::CMSO_IDLE)
        else $error("multiply length wrong");
    a_nop_length: assert property (s_nop_start |=> (q_ff.st == cmso_pkg::CMSO_RUN) [*4]
        ##1 q_ff.st == cmso_pkg::CMSO_IDLE)
        else $error("no-operation length wrong");
    a_nop_nochange: assert property (s_nop_start |=> q_ff.rf == $past(q_ff.rf)
        && q_ff.flags == $past(q_ff.flags))
        else $error("no-operation changed state");
    a_or_result: assert property (s_or_start |=> q_ff.rf[$past(dst)] == $past(or_res)
        && q_ff.flags[cmso_pkg::FL_Z] == ($past(or_res) == 8'h00) && !q_ff.flags[cmso_pkg::FL_V]
        && q_ff.flags[cmso_pkg::FL_C] == $past(q_ff.flags[cmso_pkg::FL_C]))
        else $error("OR result or flags wrong");
    a_pop_pointer: assert property (ex && (q_ff.cmd.op == cmso_pkg::OP_POP_R ||
        q_ff.cmd.op == cmso_pkg::OP_POP_IR) |=> {q_ff.rf[cmso_pkg::RF_SPH], q_ff.rf[cmso_pkg::RF_SPL]}
        == $past(sp) + 16'h0001 && q_ff.flags == $past(q_ff.flags))
        else $error("pop pointer wrong");
    a_push_store: assert property (ex && (q_ff.cmd.op == cmso_pkg::OP_PUSH_R ||
        q_ff.cmd.op == cmso_pkg::OP_PUSH_IR) |=> q_ff.rf[$past(sp[7:0]) - 8'h01] == $past(srcv)
        && q_ff.flags == $past(q_ff.flags))
        else $error("push store wrong");
    a_user_pop: assert property (ex && q_ff.cmd.op == cmso_pkg::OP_UPOP_DN && dst != uptr_a |=>
        q_ff.rf[$past(uptr_a)] == $past(q_ff.rf[uptr_a]) - 8'h01 && q_ff.rf[$past(dst)] == $past(srcv))
        else $error("decrementing user pop wrong");
    a_user_pop_up: assert property (ex && q_ff.cmd.op == cmso_pkg::OP_UPOP_UP && dst != uptr_a |=>
        q_ff.rf[$past(uptr_a)] == $past(q_ff.rf[uptr_a]) + 8'h01 && q_ff.rf[$past(dst)] == $past(srcv))
        else $error("incrementing user pop wrong");
    a_next_load: assert property (q_ff.st == cmso_pkg::CMSO_FLO && i_pmem_valid |=>
        q_ff.ip == $past(q_ff.ip) + 16'h0002 && q_ff.pc == {$past(q_ff.fhi), $past(i_pmem_data)}
        && q_ff.flags == $past(q_ff.flags))
        else $error("next load wrong");
    a_bus_answer: assert property (req && allowed && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer timing wrong");

endmodule
`default_nettype wire

//--- test/tb_cmso_exec.sv
// Self-checking bench for the multiply, OR, next, no-operation and stack slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_cmso_exec;
    logic i_mclk, i_reset, i_avs_read, i_avs_write, o_avs_waitrequest, o_pmem_rd, i_pmem_valid;
    logic [11:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, rdv;
    logic [15:0] o_pmem_addr;
    logic [7:0] i_pmem_data;
    int bad_count, checks, cyc;
    // OR cases: opcode, byte1, byte2, result place, result, flags
    logic [7:0] ort [5][6] = '{'{8'h42, 8'h01, 8'h00, 8'hc0, 8'h3f, 8'h8c},
        '{8'h43, 8'h23, 8'h00, 8'hc2, 8'h89, 8'hac}, '{8'h44, 8'h41, 8'h42, 8'h42, 8'h00, 8'hcc},
        '{8'h45, 8'h43, 8'h44, 8'h44, 8'h81, 8'hac}, '{8'h46, 8'h44, 8'h02, 8'h44, 8'h83, 8'hac}};

    cmso_exec #(.RF_DEPTH(256)) i_cmso_exec (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_pmem_addr(o_pmem_addr), .o_pmem_rd(o_pmem_rd),
        .i_pmem_data(i_pmem_data), .i_pmem_valid(i_pmem_valid));

    // ************************************************************
    // Clock, program memory stand-in, hang guard
    // ************************************************************
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    // Stalls every other cycle; data inverted while not read
    assign i_pmem_data = o_pmem_rd ? (o_pmem_addr[7:0] ^ 8'h5a) : ~(o_pmem_addr[7:0] ^ 8'h5a);
    always @(posedge i_mclk) begin
        i_pmem_valid <= o_pmem_rd & ~i_pmem_valid;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            final_report;
        end
    end

    // ************************************************************
    // Bus access and check tasks
    // ************************************************************
    function automatic logic [11:0] rf(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    // Holds the request until waitrequest is seen low; the hang guard ends a stuck wait
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        do begin
            @(posedge i_mclk);
        end while (o_avs_waitrequest !== 1'b0);
        rdv = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        `CHK(rdv, exp)
    endtask
    // Starts a command and polls busy until it clears; a stuck busy ends in the hang guard
    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        bus(1'b1, 12'h400, {8'h00, b2, b1, op});
        do begin
            bus(1'b0, 12'h404, 32'h00000000);
        end while (rdv[0] !== 1'b0);
    endtask
    task automatic final_report;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {i_reset, i_avs_read, i_avs_write, i_pmem_valid} = 4'h8;
        i_avs_address = 12'h000;
        i_avs_writedata = 32'h00000000;
        {bad_count, checks, cyc} = '0;
        repeat (20) @(posedge i_mclk);
        i_reset <= 1'b0;
        rc(rf(8'hd8), 32'h0);
        rc(12'h408, 32'h0);
        wr(rf(8'hc0), 8'h20);
        wr(rf(8'hc2), 8'h09);
        wr(12'h408, 8'h1c);
        run(8'h84, 8'hc2, 8'hc0);
        rc(rf(8'hc0), 32'h01);
        rc(rf(8'hc1), 32'h20);
        rc(12'h408, 32'h8c);
        wr(rf(8'hc3), 8'hc2);
        wr(rf(8'hc4), 8'h05);
        run(8'h85, 8'hc3, 8'hc4);
        rc(rf(8'hc5), 32'h2d);
        rc(12'h408, 32'h0c);
        wr(rf(8'hc6), 8'hff);
        run(8'h86, 8'hff, 8'hc6);
        rc(rf(8'hc6), 32'hfe);
        rc(12'h408, 32'hac);
        run(8'h86, 8'h00, 8'hc7);
        rc(rf(8'hc7), 32'h00);
        rc(12'h408, 32'h4c);
        $display("test multiply done");
        // OR operand setup, then every operand form
        wr(rf(8'hc0), 8'h15);
        wr(rf(8'hc1), 8'h2a);
        wr(rf(8'hc3), 8'h40);
        wr(rf(8'h40), 8'h80);
        wr(rf(8'h43), 8'h40);
        wr(rf(8'h44), 8'h01);
        wr(12'h408, 8'h9c);
        for (int i = 0; i < 5; i++) begin
            run(ort[i][0], ort[i][1], ort[i][2]);
            rc(rf(ort[i][3]), {24'h0, ort[i][4]});
            rc(12'h408, {24'h0, ort[i][5]});
        end
        rc(rf(8'hc1), 32'h2a);
        $display("test or done");
        wr(12'h408, 8'hfc);
        run(8'hff, 8'h00, 8'h00);
        rc(rf(8'hc0), 32'h3f);
        wr(rf(8'h45), 8'h4f);
        wr(rf(8'h46), 8'h47);
        wr(rf(8'h47), 8'ha5);
        wr(rf(8'h49), 8'h4a);
        run(8'h70, 8'h45, 8'h00);
        rc(rf(8'hd8), 32'hff);
        rc(rf(8'hff), 32'h4f);
        run(8'h71, 8'h46, 8'h00);
        rc(rf(8'hd9), 32'hfe);
        rc(rf(8'hfe), 32'ha5);
        run(8'h50, 8'h48, 8'h00);
        rc(rf(8'h48), 32'ha5);
        run(8'h51, 8'h49, 8'h00);
        rc(rf(8'h4a), 32'h4f);
        rc(rf(8'hd8), 32'h00);
        rc(rf(8'hd9), 32'h00);
        $display("test system stack done");
        wr(rf(8'h00), 8'h42);
        wr(rf(8'h42), 8'h6f);
        wr(rf(8'h41), 8'h70);
        run(8'h92, 8'h00, 8'h02);
        rc(rf(8'h02), 32'h6f);
        rc(rf(8'h00), 32'h41);
        run(8'h93, 8'h00, 8'h03);
        rc(rf(8'h03), 32'h70);
        rc(rf(8'h00), 32'h42);
        $display("test user stack done");
        bus(1'b1, 12'h410, 32'h00001234);
        run(8'h0f, 8'h00, 8'h00);
        rc(12'h40c, 32'h6e6f);
        rc(12'h410, 32'h1236);
        rc(12'h408, 32'hfc);
        run(8'h00, 8'h00, 8'h00);
        rc(12'h404, 32'h2);
        wr(12'h404, 8'h02);
        rc(12'h404, 32'h0);
        rc(12'h414, 32'h0);
        $display("test next and errors done");
        final_report;
    end
endmodule
`default_nettype wire
